// [hdl/rcf_pkg.sv]
// Package for the reset-cause flag block: register offsets, bit positions, reset values.
// Assumes a 32-bit APB slave with each register on one aligned word.
package rcf_pkg;
	localparam logic [7:0] REG_CAUSE_OFS = 8'h00;
	localparam logic [7:0] REG_STATE_OFS = 8'h04;
	localparam int BIT_TRAP = 15;
	localparam int BIT_ILLEGAL = 14;
	localparam int BIT_STANDBY = 8;
	localparam int BIT_EXTPIN = 7;
	localparam int BIT_SOFTRST = 6;
	localparam int BIT_WDTEN = 5;
	localparam int BIT_WDT_TIMEOUT = 4;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_IDLE = 2;
	localparam logic [15:0] CAUSE_RESET = 16'h0000;
	localparam logic [15:0] CAUSE_WMASK = 16'hC1FC;
	localparam int SYNC_STAGES = 2;
endpackage

// [hdl/rcf_event_flag.sv]
// One sticky cause flag: hardware event sets, software write loads.
// Assumes event and write strobes are synchronous to clk.
`timescale 1ns/1ps
module rcf_event_flag (
	input wire logic clk,
	input wire logic rstn,
	input wire logic setEvt,
	input wire logic wrEn,
	input wire logic wrVal,
	output logic flag
);
	logic flag_r;
	logic flag_nxt;

	always_comb begin
		flag_nxt = flag_r;
		if (wrEn) begin
			flag_nxt = wrVal;
		end
		// Event wins over a clearing write
		if (setEvt) begin
			flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	assign flag = flag_r;

	setWins_a: assert property (@(posedge clk) disable iff (!rstn) setEvt |=> flag_r) // RULE_10
		else $error("flag lost an event");
	holdFlag_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
		(!setEvt && !wrEn && flag_r) |=> flag_r)
		else $error("flag dropped without write");
endmodule // rcf_event_flag

// [hdl/rcf_reset_cause.sv]
// Reset-cause status register with watchdog enable, reached over APB.
// Assumes rstn is the power-on reset; other resets arrive as one-cycle cause pulses.
// Behaviour
// RULE_01 - Trap conflict reset sets bit 15
// RULE_02 - Illegal access resets, sets bit 14
// RULE_03 - Master-clear pin reset sets bit 7
// RULE_04 - Reset instruction sets bit 6
// RULE_05 - Bit 5 enables watchdog; config forces it
// RULE_06 - Watchdog time-out sets bit 4
// RULE_07 - Having slept sets bit 3
// RULE_08 - Having idled sets bit 2
// RULE_09 - Software writes flags, never causing reset
// RULE_10 - Flags persist until software or power-on
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module rcf_reset_cause (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic trapConflictEvt,
	input wire logic illegalAccessEvt,
	input wire logic masterClearPinEvt,
	input wire logic resetInstrEvt,
	input wire logic watchdogTimeoutEvt,
	input wire logic sleepEntryEvt,
	input wire logic idleEntryEvt,
	input wire logic configWatchdogForce,
	output logic watchdogRun,
	output logic coreResetReq,
	output logic regulatorSleepStandby
);
	typedef enum logic [1:0] {IDLE_ST, ACCESS_ST} rcf_apb_type;

	rcf_apb_type apbState_r, apbState_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic wdtEn_r, wdtEn_nxt;
	logic standby_r, standby_nxt;
	logic run_r, run_nxt;
	logic rstReq_r, rstReq_nxt;
	logic [15:0] causeVal;
	logic [7:0] setVec;
	logic [7:0] flagVec;
	logic causeWr;
	logic accessPhase;

	assign accessPhase = psel && penable && !pready_r;
	assign causeWr = psel && penable && pready_r && pwrite && (paddr == rcf_pkg::REG_CAUSE_OFS);

	// Event vector, index order bit15,14,7,6,4,3,2 then spare
	assign setVec = {trapConflictEvt, illegalAccessEvt, masterClearPinEvt, resetInstrEvt,
		watchdogTimeoutEvt, sleepEntryEvt, idleEntryEvt, 1'b0};

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : gFlag
			localparam int POS = (gi == 0) ? rcf_pkg::BIT_TRAP :
				(gi == 1) ? rcf_pkg::BIT_ILLEGAL :
				(gi == 2) ? rcf_pkg::BIT_EXTPIN :
				(gi == 3) ? rcf_pkg::BIT_SOFTRST :
				(gi == 4) ? rcf_pkg::BIT_WDT_TIMEOUT :
				(gi == 5) ? rcf_pkg::BIT_SLEEP : rcf_pkg::BIT_IDLE;
			rcf_event_flag uFlag (
				.clk(clk),
				.rstn(rstn),
				.setEvt(setVec[7 - gi]), // RULE_01 RULE_02 RULE_03 RULE_04 RULE_06 RULE_07 RULE_08
				.wrEn(causeWr && pstrb[POS / 8]), // RULE_09
				.wrVal(pwdata[POS]),
				.flag(flagVec[7 - gi])
			);
		end
	endgenerate
	assign flagVec[0] = 1'b0;

	always_comb begin
		causeVal = rcf_pkg::CAUSE_RESET;
		causeVal[rcf_pkg::BIT_TRAP] = flagVec[7];
		causeVal[rcf_pkg::BIT_ILLEGAL] = flagVec[6];
		causeVal[rcf_pkg::BIT_STANDBY] = standby_r;
		causeVal[rcf_pkg::BIT_EXTPIN] = flagVec[5];
		causeVal[rcf_pkg::BIT_SOFTRST] = flagVec[4];
		causeVal[rcf_pkg::BIT_WDTEN] = wdtEn_r;
		causeVal[rcf_pkg::BIT_WDT_TIMEOUT] = flagVec[3];
		causeVal[rcf_pkg::BIT_SLEEP] = flagVec[2];
		causeVal[rcf_pkg::BIT_IDLE] = flagVec[1];
	end

	// APB slave, one wait state, answer in the second access cycle
	always_comb begin
		apbState_nxt = apbState_r;
		prdata_nxt = prdata_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		wdtEn_nxt = wdtEn_r;
		standby_nxt = standby_r;
		case (apbState_r)
			IDLE_ST: begin
				if (accessPhase) begin
					apbState_nxt = ACCESS_ST;
					pready_nxt = 1'b1;
					prdata_nxt = 32'h0000_0000;
					if (paddr == rcf_pkg::REG_CAUSE_OFS) begin
						if (!pwrite) begin
							prdata_nxt = {16'h0000, causeVal};
						end
					end else if (paddr == rcf_pkg::REG_STATE_OFS) begin
						if (!pwrite) begin
							prdata_nxt = {30'h0000_0000, configWatchdogForce, run_r};
						end else begin
							pslverr_nxt = 1'b1;
						end
					end else begin
						pslverr_nxt = 1'b1;
					end
				end
			end
			ACCESS_ST: begin
				apbState_nxt = IDLE_ST;
				// Writes land on the edge that completes the transfer
				if (causeWr) begin
					if (pstrb[rcf_pkg::BIT_WDTEN / 8]) begin
						wdtEn_nxt = pwdata[rcf_pkg::BIT_WDTEN]; // RULE_05
					end
					if (pstrb[rcf_pkg::BIT_STANDBY / 8]) begin
						standby_nxt = pwdata[rcf_pkg::BIT_STANDBY];
					end
				end
			end
			default: begin
				apbState_nxt = IDLE_ST;
			end
		endcase
	end

	always_comb begin
		run_nxt = configWatchdogForce || wdtEn_r; // RULE_05
		// Only trap conflict and illegal access request a core reset
		rstReq_nxt = trapConflictEvt || illegalAccessEvt; // RULE_02 RULE_09
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			apbState_r <= IDLE_ST;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			wdtEn_r <= 1'b0;
			standby_r <= 1'b0;
			run_r <= 1'b0;
			rstReq_r <= 1'b0;
		end else begin
			apbState_r <= apbState_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			wdtEn_r <= wdtEn_nxt;
			standby_r <= standby_nxt;
			run_r <= run_nxt;
			rstReq_r <= rstReq_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign watchdogRun = run_r;
	assign coreResetReq = rstReq_r;
	assign regulatorSleepStandby = standby_r;

	trapFlag_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
		trapConflictEvt |=> causeVal[rcf_pkg::BIT_TRAP] && coreResetReq)
		else $error("trap event did not set flag");
	illegalReset_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
		illegalAccessEvt |=> coreResetReq && causeVal[rcf_pkg::BIT_ILLEGAL])
		else $error("illegal access missed reset or flag");
	extPinFlag_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
		masterClearPinEvt |=> causeVal[rcf_pkg::BIT_EXTPIN])
		else $error("pin reset did not set flag");
	softRstFlag_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
		resetInstrEvt |=> causeVal[rcf_pkg::BIT_SOFTRST])
		else $error("reset instruction did not set flag");
	wdtForce_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
		$past(rstn) && (configWatchdogForce || wdtEn_r) |=> watchdogRun)
		else $error("watchdog not running when enabled");
	wdtOff_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
		(!configWatchdogForce && !wdtEn_r) |=> !watchdogRun)
		else $error("watchdog running while disabled");
	wdtWrite_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
		(causeWr && pstrb[rcf_pkg::BIT_WDTEN / 8]) |=> wdtEn_r == $past(pwdata[rcf_pkg::BIT_WDTEN]))
		else $error("watchdog enable not written");
	timeoutFlag_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
		watchdogTimeoutEvt |=> causeVal[rcf_pkg::BIT_WDT_TIMEOUT])
		else $error("timeout did not set flag");
	sleepFlag_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
		sleepEntryEvt |=> causeVal[rcf_pkg::BIT_SLEEP])
		else $error("sleep did not set flag");
	idleFlag_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
		idleEntryEvt |=> causeVal[rcf_pkg::BIT_IDLE])
		else $error("idle did not set flag");
	swNoReset_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
		(causeWr && !trapConflictEvt && !illegalAccessEvt) |=> !coreResetReq)
		else $error("software write caused reset");
	swClear_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
		(causeWr && pstrb[rcf_pkg::BIT_TRAP / 8] && !pwdata[rcf_pkg::BIT_TRAP] && !trapConflictEvt)
		|=> !causeVal[rcf_pkg::BIT_TRAP])
		else $error("software clear of trap flag lost");
	standbyWrite_a: assert property (@(posedge clk) disable iff (!rstn)
		(causeWr && pstrb[rcf_pkg::BIT_STANDBY / 8])
		|=> regulatorSleepStandby == $past(pwdata[rcf_pkg::BIT_STANDBY]))
		else $error("standby bit not written");
	readyPulse_a: assert property (@(posedge clk) disable iff (!rstn)
		pready |=> !pready)
		else $error("ready held longer than one cycle");
	errWithReady_a: assert property (@(posedge clk) disable iff (!rstn)
		pslverr |-> pready)
		else $error("error without ready");
endmodule // rcf_reset_cause

// [sim/test_reset_cause_flags.sv]
// Self-checking bench for the reset-cause register block.
// Assumes rcf_pkg and rcf_reset_cause are compiled before this file.
`timescale 1ns/1ps
module test_reset_cause_flags;
	logic clk, rstn, psel, penable, pwrite, forceWd, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [6:0] evt;
	logic pready, pslverr, wdRun, coreReq, standby;
	int mismatches = 0, checked = 0, cycles = 0, reqCount = 0, r0;
	int bitPos[7] = '{rcf_pkg::BIT_TRAP, rcf_pkg::BIT_ILLEGAL, rcf_pkg::BIT_EXTPIN, rcf_pkg::BIT_SOFTRST,
		rcf_pkg::BIT_WDT_TIMEOUT, rcf_pkg::BIT_SLEEP, rcf_pkg::BIT_IDLE};
	rcf_reset_cause DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trapConflictEvt(evt[0]), .illegalAccessEvt(evt[1]), .masterClearPinEvt(evt[2]),
		.resetInstrEvt(evt[3]), .watchdogTimeoutEvt(evt[4]), .sleepEntryEvt(evt[5]), .idleEntryEvt(evt[6]),
		.configWatchdogForce(forceWd), .watchdogRun(wdRun), .coreResetReq(coreReq),
		.regulatorSleepStandby(standby));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic close_out;
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (coreReq === 1'b1)
			reqCount <= reqCount + 1;
		if (cycles == 5000) begin
			mismatches = mismatches + 1;
			close_out();
		end
	end
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked = checked + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; waits for pready, with only the bench timeout as a limit
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		evt[i] <= 1'b1;
		@(posedge clk);
		evt <= 7'h00;
	endtask
	task automatic s_causes;
		for (int i = 0; i < 7; i++) begin
			r0 = reqCount;
			pulse(i);
			repeat (3) @(posedge clk);
			apb(1'b0, rcf_pkg::REG_CAUSE_OFS, 32'h0);
			cmp("cause flag", 32'h1 << bitPos[i], rd);
			cmp("core reset", 32'(i < 2), 32'(reqCount - r0));
			apb(1'b1, rcf_pkg::REG_CAUSE_OFS, 32'h0);
		end
	endtask
	task automatic s_persist;
		pulse(2);
		pulse(4);
		apb(1'b0, rcf_pkg::REG_CAUSE_OFS, 32'h0);
		cmp("kept flags", 32'h0090, rd);
		cmp("no error", 32'h0, 32'(err));
		r0 = reqCount;
		apb(1'b1, rcf_pkg::REG_CAUSE_OFS, 32'h0000C1DC);
		repeat (3) @(posedge clk);
		apb(1'b0, rcf_pkg::REG_CAUSE_OFS, 32'h0);
		cmp("soft set", 32'h0000C1DC, rd);
		cmp("standby on", 32'h1, 32'(standby));
		cmp("no reset", 32'h0, 32'(reqCount - r0));
	endtask
	task automatic s_watchdog;
		apb(1'b1, rcf_pkg::REG_CAUSE_OFS, 32'h00000020);
		repeat (2) @(posedge clk);
		cmp("wd on", 32'h1, 32'(wdRun));
		cmp("standby off", 32'h0, 32'(standby));
		apb(1'b0, rcf_pkg::REG_CAUSE_OFS, 32'h0);
		cmp("wd bit", 32'h20, rd);
		apb(1'b1, rcf_pkg::REG_CAUSE_OFS, 32'h0);
		repeat (2) @(posedge clk);
		cmp("wd off", 32'h0, 32'(wdRun));
		forceWd <= 1'b1;
		repeat (3) @(posedge clk);
		cmp("wd forced", 32'h1, 32'(wdRun));
		apb(1'b0, rcf_pkg::REG_STATE_OFS, 32'h0);
		cmp("state reg", 32'h3, rd);
	endtask
	task automatic s_refused;
		apb(1'b0, 8'h08, 32'h0);
		cmp("unmapped", 32'h1, 32'(err));
		apb(1'b1, rcf_pkg::REG_STATE_OFS, 32'hFFFFFFFF);
		cmp("read-only", 32'h1, 32'(err));
	endtask
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		evt = 7'h00;
		forceWd = 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, rcf_pkg::REG_CAUSE_OFS, 32'h0);
		cmp("reset value", 32'(rcf_pkg::CAUSE_RESET), rd);
		s_causes();
		s_persist();
		s_watchdog();
		s_refused();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, rcf_pkg::REG_CAUSE_OFS, 32'h0);
		cmp("power-on clear", 32'h0, rd);
		close_out();
	end
endmodule // test_reset_cause_flags
